// ==== src/host_bus_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_bus_port (
	input  wire logic                              SYS_CLK,
	input  wire logic                              ARST_N,
	input  wire logic                              CLK_EN,
	input  wire logic                              STYLE_SEL,
	input  wire logic                              HOST_CS_N,
	input  wire logic                              HOST_RNW_WR_N,
	input  wire logic                              HOST_OE_RD_N,
	input  wire logic [host_port_pkg::ADDR_W-1:0]  HOST_ADDR,
	input  wire logic [host_port_pkg::DATA_W-1:0]  HOST_DATA_I,
	output logic      [host_port_pkg::DATA_W-1:0]  HOST_DATA_O,
	output logic                                   HOST_DATA_OE_N,
	output logic                                   HOST_IRQ_O,
	output logic                                   HOST_IRQ_OE_N,
	input  wire logic                              IRQ_PENDING,
	input  wire logic [host_port_pkg::DATA_W-1:0]  RD_DATA,
	output logic      [host_port_pkg::ADDR_W-1:0]  ACC_ADDR,
	output logic      [host_port_pkg::DATA_W-1:0]  WR_DATA,
	output logic                                   WR_STB,
	output logic                                   RD_STB
);
	localparam int PIN_W = $bits(host_port_pkg::host_pins_t);

	host_port_pkg::host_pins_t  pins_raw;
	host_port_pkg::host_pins_t  pins;
	host_port_pkg::port_regs_t  r_q;
	host_port_pkg::port_regs_t  r_d;
	logic                       rd_req;
	logic                       wr_req;

	assign pins_raw = '{cs_n: HOST_CS_N, rnw_wr_n: HOST_RNW_WR_N, oe_rd_n: HOST_OE_RD_N,
		addr: HOST_ADDR, data: HOST_DATA_I};

	pin_sync #(
		.WIDTH (PIN_W),
		.RST   (1'b1)
	) u_sync (
		.clk    (SYS_CLK),
		.arst_n (ARST_N),
		.en     (CLK_EN),
		.d      (pins_raw),
		.q      (pins)
	);

	// Decode the two bus styles into read and write requests
	always_comb begin
		rd_req = 1'b0;
		wr_req = 1'b0;
		if (!pins.cs_n) begin
			if (r_q.style == host_port_pkg::STYLE_RNW) begin
				// Output enable is assumed tied low in this style
				rd_req = pins.rnw_wr_n && !pins.oe_rd_n;
				wr_req = !pins.rnw_wr_n;
			end else begin
				rd_req = !pins.oe_rd_n && pins.rnw_wr_n;
				wr_req = !pins.rnw_wr_n;
			end
		end
	end

	always_comb begin
		r_d           = r_q;
		r_d.wr_stb    = 1'b0;
		r_d.rd_stb    = 1'b0;
		r_d.irq_oe_n  = !IRQ_PENDING;
		r_d.rdata     = RD_DATA;
		case (r_q.state)
			host_port_pkg::ST_IDLE: begin
				r_d.data_oe_n = 1'b1;
				r_d.style     = STYLE_SEL;
				if (rd_req) begin
					r_d.addr   = pins.addr;
					r_d.rd_stb = 1'b1;
					r_d.state  = host_port_pkg::ST_READ;
				end else if (wr_req) begin
					r_d.addr   = pins.addr;
					r_d.wdata  = pins.data;
					r_d.state  = host_port_pkg::ST_WRITE;
				end
			end
			host_port_pkg::ST_READ: begin
				// Drive returned data while the read lasts
				r_d.data_out  = RD_DATA;
				r_d.data_oe_n = 1'b0;
				if (!rd_req) begin
					r_d.data_oe_n = 1'b1;
					r_d.state     = host_port_pkg::ST_DONE;
				end
			end
			host_port_pkg::ST_WRITE: begin
				// Sample data while strobe held; commit on its release
				if (wr_req) begin
					r_d.wdata = pins.data;
				end else begin
					r_d.wr_stb = 1'b1;
					r_d.state  = host_port_pkg::ST_DONE;
				end
			end
			host_port_pkg::ST_DONE: begin
				r_d.data_oe_n = 1'b1;
				r_d.state     = host_port_pkg::ST_IDLE;
			end
			default: begin
				r_d.state = host_port_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			r_q.rdata     <= host_port_pkg::DATA_RST;
			r_q.data_out  <= host_port_pkg::DATA_RST;
			r_q.data_oe_n <= 1'b1;
			r_q.irq_oe_n  <= 1'b1;
			r_q.addr      <= host_port_pkg::ADDR_RST;
			r_q.wdata     <= host_port_pkg::DATA_RST;
			r_q.wr_stb    <= 1'b0;
			r_q.rd_stb    <= 1'b0;
			r_q.style     <= host_port_pkg::STYLE_RNW;
			r_q.state     <= host_port_pkg::ST_IDLE;
		end else if (CLK_EN) begin
			r_q <= r_d;
		end
	end

	assign HOST_DATA_O    = r_q.data_out;
	assign HOST_DATA_OE_N = r_q.data_oe_n;
	assign HOST_IRQ_O     = 1'b0;
	assign HOST_IRQ_OE_N  = r_q.irq_oe_n;
	assign ACC_ADDR       = r_q.addr;
	assign WR_DATA        = r_q.wdata;
	assign WR_STB         = r_q.wr_stb;
	assign RD_STB         = r_q.rd_stb;
endmodule
`default_nettype wire

// ==== src/host_port_pkg.sv ====
package host_port_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 12;
	localparam int SYNC_W = 2;

	// Last stage index of the synchroniser
	localparam int SYNC_LAST = 1;

	localparam logic       STYLE_RNW    = 1'b0;
	localparam logic       STYLE_STROBE = 1'b1;
	localparam logic [1:0] SYNC_RST     = 2'h3;

	// One-bit steps along idle -> read/write -> done -> idle, except idle -> write and read -> done
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_READ  = 2'h1,
		ST_WRITE = 2'h3,
		ST_DONE  = 2'h2
	} port_state_t;

	typedef struct packed {
		logic              cs_n;
		logic              rnw_wr_n;
		logic              oe_rd_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} host_pins_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] data_out;
		logic              data_oe_n;
		logic              irq_oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr_stb;
		logic              rd_stb;
		logic              style;
		port_state_t       state;
	} port_regs_t;

	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

endpackage

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int          WIDTH = 1,
	parameter logic [0:0]  RST   = 1'b0
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             en,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_t;

	sync_t r_q;
	sync_t r_d;

	// First stage is read by the second stage only
	always_comb begin
		r_d    = r_q;
		r_d.s1 = d;
		r_d.s2 = r_q.s1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r_q <= {(2 * WIDTH){RST}};
		end else if (en) begin
			r_q <= r_d;
		end
	end

	assign q = r_q.s2;
endmodule
`default_nettype wire

// ==== test/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic        clk,
	input  wire logic        sty,
	output logic             cs_n,
	output logic             wr_n,
	output logic             rd_n,
	output logic [11:0]      a,
	output logic [15:0]      d
);
	initial {cs_n, wr_n, rd_n, a, d} = 31'h7FFFFFFF;
	// One access, chip select left high when sel is low
	task automatic acc(input logic sel, input logic w, input logic [27:0] v);
		@(posedge clk);
		cs_n <= !sel;
		wr_n <= !w;
		rd_n <= w & sty;
		{a, d} <= v;
		repeat (8) @(posedge clk);
		{cs_n, wr_n, rd_n} <= {2'h3, sty};
		d <= ~v[15:0];
		repeat (6) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ==== test/host_port_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_port_checker (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic CLK_EN,
	input wire logic HOST_CS_N,
	input wire logic HOST_RNW_WR_N,
	input wire logic HOST_DATA_OE_N,
	input wire logic HOST_IRQ_OE_N,
	input wire logic IRQ_PENDING,
	input wire logic WR_STB,
	input wire logic RD_STB
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N || !CLK_EN);
	sequence s_rd; RD_STB ##1 !HOST_DATA_OE_N; endsequence
	sequence s_wr; WR_STB ##1 !WR_STB; endsequence
	property p_rd; RD_STB |-> s_rd; endproperty
	a_rd: assert property (p_rd) else $error("read data not driven");
	property p_wr; WR_STB |-> s_wr; endproperty
	a_wr: assert property (p_wr) else $error("write pulse too long");
	property p_irq_on; IRQ_PENDING |=> !HOST_IRQ_OE_N; endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq not pulled");
	property p_irq_off; !IRQ_PENDING |=> HOST_IRQ_OE_N; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq not released");
	property p_cs_wr; HOST_CS_N [*6] |-> !WR_STB; endproperty
	a_cs_wr: assert property (p_cs_wr) else $error("write while idle");
	property p_cs_oe; HOST_CS_N [*6] |-> HOST_DATA_OE_N; endproperty
	a_cs_oe: assert property (p_cs_oe) else $error("bus driven while idle");
	property p_oe_rd; !HOST_DATA_OE_N |-> $past(!HOST_CS_N && HOST_RNW_WR_N, 3); endproperty
	a_oe_rd: assert property (p_oe_rd) else $error("bus driven off read");
	property p_wr_oe; WR_STB |-> HOST_DATA_OE_N; endproperty
	a_wr_oe: assert property (p_wr_oe) else $error("bus driven in write");
endmodule
bind host_bus_port host_port_checker chk (.*);
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sty = 1'b0;
	logic        irq = 1'b0;
	logic        prv = 1'b1;
	logic        irq_q = 1'b0;
	logic        rst_q = 1'b0;
	logic        irq_o, irq_oe_n;
	logic        cs_n, wr_n, rd_n, oe_n, wstb;
	logic [11:0] a, acc;
	logic [15:0] d, dout, wd;
	logic [27:0] exp_q[$];
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc = 0;
	always #2 clk = ~clk;
	host_model mdl (.clk(clk), .sty(sty), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .a(a), .d(d));
	host_bus_port dut (.SYS_CLK(clk), .ARST_N(rst_n), .CLK_EN(1'b1), .STYLE_SEL(sty),
		.HOST_CS_N(cs_n), .HOST_RNW_WR_N(wr_n), .HOST_OE_RD_N(rd_n), .HOST_ADDR(a),
		.HOST_DATA_I(oe_n ? d : dout), .HOST_DATA_O(dout), .HOST_DATA_OE_N(oe_n),
		.HOST_IRQ_O(irq_o), .HOST_IRQ_OE_N(irq_oe_n), .IRQ_PENDING(irq),
		.RD_DATA({4'h0, acc} ^ 16'hA5A5), .ACC_ADDR(acc), .WR_DATA(wd), .WR_STB(wstb),
		.RD_STB());
	task automatic chk(input logic [27:0] got, input logic [27:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		irq <= 1'($urandom);
		irq_q <= irq;
		rst_q <= rst_n;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	// Outputs are looked at mid-cycle, where they have settled
	always @(negedge clk) begin
		prv <= oe_n;
		if (wstb || (prv && !oe_n))
			chk({acc, wstb ? wd : dout}, exp_q.size() ? exp_q.pop_front() : 28'hX);
		if (rst_q)
			chk(28'({irq_oe_n, irq_o}), 28'({!irq_q, 1'b0}));
	end
	initial begin
		logic [27:0] v;
		logic        w;
		logic        sel;
		void'($urandom(32'hC0FB));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			v = 28'($urandom);
			w = 1'($urandom);
			sel = i % 4 != 3;
			sty <= i >= 12;
			if (sel)
				exp_q.push_back(w ? v : {v[27:16], {4'h0, v[27:16]} ^ 16'hA5A5});
			mdl.acc(sel, w, v);
		end
		chk(28'(exp_q.size()), 28'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
